// ---- cpg_pkg.sv ----
// shared constants for the contour path and gearing block
package cpg_pkg;
   localparam int unsigned SPLINE_DEPTH = 128;
   localparam int unsigned QPTR_W       = 8;
   localparam int unsigned POS_W        = 32;
   localparam int unsigned RATIO_W      = 32;
   localparam int unsigned RATIO_FRAC   = 16;
   localparam int unsigned DIST_W       = 48;
   localparam int unsigned TIME_W       = 32;
   localparam int unsigned SPD_W        = 16;
   localparam logic [7:0]  SQRT_STEPS   = 8'h18;
   localparam logic [7:0]  GO_SPLINE_PARAM = 8'h01;
   typedef enum logic [1:0] {CPG_IDLE, CPG_SQRT, CPG_DIV, CPG_DONE} cpg_state_e;
endpackage

// ---- cpg_contour_gear.sv ----
// contour distance, period, spline queue and electronic gearing for a 3-axis group
// Function
// (RULE_01) host enables synch mode before contour moves
// (RULE_02) host starts queue with extended go one
// (RULE_03) spline run sweeps first to last point
// (RULE_04) spline queue holds at most 128 moves
// (RULE_05) clearing synch mode stops spline fitting
// (RULE_06) orthogonal distance is root of squares; code squares only the low 16 bits of each axis displacement
// (RULE_07) period from vector accel, speed, decel
// (RULE_08) host opens user path with select zero
// (RULE_09) host ends user block with distance
// (RULE_10) user distance absolute from mode-set positions
// (RULE_11) mode set clears contour distance
// (RULE_12) zero distance uses longest axis time
// (RULE_13) zero distance ignores group vector speed
// (RULE_14) each axis kept under own speed
// (RULE_15) all axes start and stop together
// (RULE_16) slave target is master times ratio
// (RULE_17) negative ratio reverses slave direction
// (RULE_18) ratio is signed fixed point value
// (RULE_19) gearing works in every master mode
// (RULE_20) error on any geared axis stops group
// (RULE_21) host loads slave gains before gearing
// (RULE_22) host avoids ratio change while moving
// (RULE_23) slave target recomputed every servo tick; code skips ticks while o_group_stop is set
module cpg_contour_gear #(
   parameter int unsigned NAX = 3
) (
   // clock and reset
   input  wire logic                                      i_mclk,
   input  wire logic                                      i_rst,
   // mode and queue control
   input  wire logic                                      i_contour_synch_enable,
   input  wire logic                                      i_operating_mode_set,
   input  wire logic                                      i_queue_push,
   input  wire logic                                      i_extended_go,
   input  wire logic [7:0]                                i_extended_go_param,
   input  wire logic                                      i_point_done,
   // move request
   input  wire logic                                      i_move_start,
   input  wire logic                                      i_user_path_block_mode,
   input  wire logic [cpg_pkg::DIST_W-1:0]                i_contour_distance_set,
   input  wire logic [NAX*cpg_pkg::POS_W-1:0]             i_target,
   input  wire logic [NAX*cpg_pkg::POS_W-1:0]             i_position,
   input  wire logic [cpg_pkg::SPD_W-1:0]                 i_vector_speed_set,
   input  wire logic [cpg_pkg::SPD_W-1:0]                 i_vector_accel,
   input  wire logic [cpg_pkg::SPD_W-1:0]                 i_vector_decel,
   input  wire logic [NAX*cpg_pkg::SPD_W-1:0]             i_axis_speed_set,
   input  wire logic [NAX*cpg_pkg::SPD_W-1:0]             i_axis_accel,
   // gearing
   input  wire logic                                      i_servo_tick,
   input  wire logic [cpg_pkg::POS_W-1:0]                 i_master_optimal,
   input  wire logic [NAX-1:0]                            i_slave_gearing_enable,
   input  wire logic [NAX*cpg_pkg::RATIO_W-1:0]           i_ratio,
   input  wire logic [NAX:0]                              i_axis_error,
   // results
   output logic                                           o_spline_active,
   output logic [cpg_pkg::QPTR_W-1:0]                     o_queue_count,
   output logic                                           o_queue_full,
   output logic [cpg_pkg::DIST_W-1:0]                     o_contour_distance,
   output logic [cpg_pkg::TIME_W-1:0]                     o_move_time,
   output logic [NAX*cpg_pkg::SPD_W-1:0]                  o_axis_speed,
   output logic                                           o_move_valid,
   output logic [NAX*cpg_pkg::POS_W-1:0]                  o_slave_target,
   output logic                                           o_group_stop
);
   localparam int unsigned DW = cpg_pkg::DIST_W;
   localparam int unsigned TW = cpg_pkg::TIME_W;
   localparam int unsigned SW = cpg_pkg::SPD_W;
   localparam int unsigned PW = cpg_pkg::POS_W;
   localparam int unsigned RW = cpg_pkg::RATIO_W;

   cpg_pkg::cpg_state_e                  st_r;
   logic [cpg_pkg::QPTR_W-1:0]           qcnt_r;
   logic                                 spl_r;
   logic [NAX*PW-1:0]                    base_r;
   logic [DW-1:0]                        acc_r;
   logic [DW-1:0]                        sq_r;
   logic [DW-1:0]                        root_r;
   logic [7:0]                           step_r;
   logic [DW-1:0]                        dist_r;
   logic [TW-1:0]                        time_r;
   logic                                 zmode_r;
   logic [NAX*SW-1:0]                    spd_r;
   logic                                 valid_r;
   logic [NAX*PW-1:0]                    slv_r;
   logic                                 stop_r;

   // absolute per-axis displacement and time estimates
   logic [NAX*PW-1:0]                    disp;
   logic [DW-1:0]                        sumsq;
   logic [TW-1:0]                        ax_time [NAX];
   logic [TW-1:0]                        tmax;
   logic [TW-1:0]                        vtime;
   logic [DW-1:0]                        udist;
   logic                                 qfull;
   logic [cpg_pkg::QPTR_W-1:0]           qcnt_nxt;
   logic                                 full_r;

   assign qfull = full_r;

   always_comb
   begin
      logic [PW-1:0] d;
      logic [PW-1:0] t;
      logic [SW-1:0] v;
      logic [SW-1:0] a;
      d     = '0;
      t     = '0;
      v     = '0;
      a     = '0;
      sumsq = '0;
      tmax  = '0;
      udist = '0;
      disp  = '0;
      ax_time = '{default: '0};
      for (int k = 0; k < NAX; k++)
      begin
         t = i_target[k*PW +: PW] - i_position[k*PW +: PW];
         d = t[PW-1] ? (~t + PW'(1)) : t;
         disp[k*PW +: PW] = d;
         // (RULE_06) sum of squares of the low 16 bits of each displacement
         sumsq = sumsq + DW'(d[PW/2-1:0] * d[PW/2-1:0]);
         // (RULE_10) absolute from base
         t = i_target[k*PW +: PW] - base_r[k*PW +: PW];
         udist = udist + DW'(t[PW-1] ? (~t + PW'(1)) : t);
         v = (i_axis_speed_set[k*SW +: SW] == '0) ? SW'(1) : i_axis_speed_set[k*SW +: SW];
         a = (i_axis_accel[k*SW +: SW] == '0) ? SW'(1) : i_axis_accel[k*SW +: SW];
         // (RULE_12) trapezoid time d/v + v/a
         ax_time[k] = TW'(d / PW'(v)) + TW'(v / a);
         if (ax_time[k] > tmax)
            tmax = ax_time[k];
      end
   end

   // (RULE_07) vector period from accel, speed, decel
   always_comb
   begin
      logic [SW-1:0] vv;
      logic [SW-1:0] va;
      logic [SW-1:0] vd;
      vv = (i_vector_speed_set == '0) ? SW'(1) : i_vector_speed_set;
      va = (i_vector_accel == '0) ? SW'(1) : i_vector_accel;
      vd = (i_vector_decel == '0) ? SW'(1) : i_vector_decel;
      vtime = TW'(dist_r / DW'(vv)) + TW'(vv / (2*va)) + TW'(vv / (2*vd));
   end

   // (RULE_04) queue bounded in spline mode
   always_comb
   begin
      qcnt_nxt = qcnt_r;
      if (!i_contour_synch_enable)
         qcnt_nxt = '0;
      else if (i_queue_push && !qfull && !spl_r)
         qcnt_nxt = qcnt_r + cpg_pkg::QPTR_W'(1);
      else if (i_point_done && spl_r && qcnt_r != '0)
         qcnt_nxt = qcnt_r - cpg_pkg::QPTR_W'(1);
   end

   // full flag taken from the next count so it never lags the count
   always_ff @(posedge i_mclk)
   begin
      if (i_rst)
      begin
         qcnt_r <= '0;
         full_r <= 1'b0;
      end
      else
      begin
         qcnt_r <= qcnt_nxt;
         full_r <= (qcnt_nxt == cpg_pkg::QPTR_W'(cpg_pkg::SPLINE_DEPTH));
      end
   end

   // (RULE_03) run until last point consumed
   always_ff @(posedge i_mclk)
   begin
      if (i_rst)
         spl_r <= 1'b0;
      // (RULE_05) clearing synch stops fitting
      else if (!i_contour_synch_enable)
         spl_r <= 1'b0;
      else if (i_extended_go && i_extended_go_param == cpg_pkg::GO_SPLINE_PARAM && qcnt_r != '0)
         spl_r <= 1'b1;
      else if (spl_r && i_point_done && qcnt_r == cpg_pkg::QPTR_W'(1))
         spl_r <= 1'b0;
   end

   // (RULE_11) mode set latches base positions
   always_ff @(posedge i_mclk)
   begin
      if (i_rst)
         base_r <= '0;
      else if (i_operating_mode_set)
         base_r <= i_position;
   end

   // distance and period sequencer; root found bit-serially
   always_ff @(posedge i_mclk)
   begin
      if (i_rst)
      begin
         st_r    <= cpg_pkg::CPG_IDLE;
         acc_r   <= '0;
         sq_r    <= '0;
         root_r  <= '0;
         step_r  <= '0;
         dist_r  <= '0;
         time_r  <= '0;
         zmode_r <= 1'b0;
         valid_r <= 1'b0;
      end
      else
      begin
         valid_r <= 1'b0;
         case (st_r)
            cpg_pkg::CPG_IDLE:
            begin
               // (RULE_11) clear on mode set
               if (i_operating_mode_set)
                  dist_r <= '0;
               else if (i_move_start && i_user_path_block_mode)
               begin
                  // (RULE_13) zero distance uses axis speeds
                  zmode_r <= (i_contour_distance_set == '0);
                  dist_r  <= (i_contour_distance_set == '0) ? udist : i_contour_distance_set;
                  st_r    <= cpg_pkg::CPG_DIV;
               end
               else if (i_move_start)
               begin
                  zmode_r <= 1'b0;
                  sq_r    <= sumsq;
                  root_r  <= '0;
                  acc_r   <= '0;
                  step_r  <= cpg_pkg::SQRT_STEPS;
                  st_r    <= cpg_pkg::CPG_SQRT;
               end
            end
            cpg_pkg::CPG_SQRT:
            begin
               // (RULE_06) restoring square root
               if (step_r == '0)
               begin
                  dist_r <= root_r;
                  st_r   <= cpg_pkg::CPG_DIV;
               end
               else
               begin
                  if (({acc_r[DW-3:0], sq_r[DW-1 -: 2]}) >= {root_r[DW-3:0], 2'b01})
                  begin
                     acc_r  <= {acc_r[DW-3:0], sq_r[DW-1 -: 2]} - {root_r[DW-3:0], 2'b01};
                     root_r <= {root_r[DW-2:0], 1'b1};
                  end
                  else
                  begin
                     acc_r  <= {acc_r[DW-3:0], sq_r[DW-1 -: 2]};
                     root_r <= {root_r[DW-2:0], 1'b0};
                  end
                  sq_r   <= {sq_r[DW-3:0], 2'b00};
                  step_r <= step_r - 8'h01;
               end
            end
            cpg_pkg::CPG_DIV:
            begin
               // (RULE_12) longest axis sets time
               time_r <= zmode_r ? tmax : vtime;
               st_r   <= cpg_pkg::CPG_DONE;
            end
            cpg_pkg::CPG_DONE:
            begin
               // (RULE_15) one valid for whole group
               valid_r <= 1'b1;
               st_r    <= cpg_pkg::CPG_IDLE;
            end
            default:
               st_r <= cpg_pkg::CPG_IDLE;
         endcase
      end
   end

   // (RULE_14) speed scaled to shared time, capped at axis maximum
   always_ff @(posedge i_mclk)
   begin
      if (i_rst)
         spd_r <= '0;
      else if (st_r == cpg_pkg::CPG_DONE && zmode_r)
      begin
         for (int k = 0; k < NAX; k++)
         begin
            if (time_r == '0 || ax_time[k] >= time_r)
               spd_r[k*SW +: SW] <= i_axis_speed_set[k*SW +: SW];
            else
               spd_r[k*SW +: SW] <= SW'((disp[k*PW +: PW] * i_axis_speed_set[k*SW +: SW])
                                        / (disp[k*PW +: PW] + PW'(1)) * ax_time[k] / time_r);
         end
      end
   end

   // (RULE_20) error on any geared axis stops group
   always_ff @(posedge i_mclk)
   begin
      if (i_rst)
         stop_r <= 1'b0;
      else if (i_slave_gearing_enable == '0)
         stop_r <= 1'b0;
      else if (i_axis_error != '0)
         stop_r <= 1'b1;
   end

   // (RULE_23) recomputed on every servo tick; frozen after a group stop
   always_ff @(posedge i_mclk)
   begin
      if (i_rst)
         slv_r <= '0;
      else if (i_servo_tick && !stop_r)
      begin
         for (int k = 0; k < NAX; k++)
         begin
            // (RULE_16) signed product, ratio fraction dropped
            // (RULE_17) sign of ratio sets direction
            // (RULE_18) signed fixed-point ratio
            // (RULE_19) no master mode gating
            if (i_slave_gearing_enable[k])
               slv_r[k*PW +: PW] <= PW'((64'($signed(i_master_optimal))
                                       * 64'($signed(i_ratio[k*RW +: RW])))
                                       >>> cpg_pkg::RATIO_FRAC);
         end
      end
   end

   assign o_spline_active    = spl_r;
   assign o_queue_count      = qcnt_r;
   assign o_queue_full       = full_r;
   assign o_contour_distance = dist_r;
   assign o_move_time        = time_r;
   assign o_axis_speed       = spd_r;
   assign o_move_valid       = valid_r;
   assign o_slave_target     = slv_r;
   assign o_group_stop       = stop_r;
endmodule

// ---- cpg_contour_gear_props.sv ----
// port assertions for the contour path and gearing block
module cpg_props #(
   parameter int unsigned NAX = 3
) (
   input  wire logic                            i_mclk,
   input  wire logic                            i_rst,
   input  wire logic                            i_contour_synch_enable,
   input  wire logic                            i_extended_go,
   input  wire logic [7:0]                      i_extended_go_param,
   input  wire logic                            i_servo_tick,
   input  wire logic [cpg_pkg::POS_W-1:0]       i_master_optimal,
   input  wire logic [NAX-1:0]                  i_slave_gearing_enable,
   input  wire logic [NAX*cpg_pkg::RATIO_W-1:0] i_ratio,
   input  wire logic [NAX:0]                    i_axis_error,
   input  wire logic                            o_spline_active,
   input  wire logic [cpg_pkg::QPTR_W-1:0]      o_queue_count,
   input  wire logic                            o_queue_full,
   input  wire logic                            o_move_valid,
   input  wire logic [NAX*cpg_pkg::POS_W-1:0]   o_slave_target,
   input  wire logic                            o_group_stop
);
   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (i_rst);
   logic signed [63:0] prod0;
   assign prod0 = $signed(i_master_optimal) * $signed(i_ratio[31:0]);
   full_flag_a: assert property (o_queue_full == (o_queue_count == 8'h80))
      else $error("queue full flag disagrees with count");
   queue_cap_a: assert property (o_queue_count <= 8'h80)
      else $error("queue count above depth");
   synch_drop_a: assert property (!i_contour_synch_enable |=> !o_spline_active)
      else $error("spline still active after synch cleared");
   synch_empty_a: assert property (!i_contour_synch_enable |=> o_queue_count == 8'h00)
      else $error("queue not emptied after synch cleared");
   spline_go_a: assert property (i_extended_go && i_extended_go_param == 8'h01
      && i_contour_synch_enable && o_queue_count != 8'h00 |=> o_spline_active)
      else $error("extended go did not start spline run");
   valid_pulse_a: assert property (o_move_valid |=> !o_move_valid)
      else $error("move valid longer than one cycle");
   gear_track_a: assert property (i_servo_tick && i_slave_gearing_enable[0] && !o_group_stop
      |=> o_slave_target[31:0] == $past(prod0[47:16]))
      else $error("slave target not master times ratio");
   error_stop_a: assert property ((|i_axis_error) && (|i_slave_gearing_enable)
      |=> o_group_stop)
      else $error("group not stopped on axis error");
   stop_hold_a: assert property (o_group_stop |=> $stable(o_slave_target))
      else $error("slave target moved while stopped");
   cover property (o_queue_full);
   cover property (o_group_stop);
   cover property (o_move_valid);
endmodule

bind cpg_contour_gear cpg_props #(.NAX(NAX)) u_props (.i_mclk(i_mclk), .i_rst(i_rst),
   .i_contour_synch_enable(i_contour_synch_enable), .i_extended_go(i_extended_go),
   .i_extended_go_param(i_extended_go_param), .i_servo_tick(i_servo_tick),
   .i_master_optimal(i_master_optimal), .i_slave_gearing_enable(i_slave_gearing_enable),
   .i_ratio(i_ratio), .i_axis_error(i_axis_error), .o_spline_active(o_spline_active),
   .o_queue_count(o_queue_count), .o_queue_full(o_queue_full), .o_move_valid(o_move_valid),
   .o_slave_target(o_slave_target), .o_group_stop(o_group_stop));

// ---- cpg_contour_gear_tb_top.sv ----
// self-checking bench for the contour path and gearing block
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin mismatches++; \
   $display("[ERR] %s exp %0h got %0h", n, e, g); end end
module cpg_contour_gear_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic i_mclk = 0, i_rst = 1, i_contour_synch_enable = 0, i_operating_mode_set = 0;
   logic i_queue_push = 0, i_extended_go = 0, i_point_done = 0, i_move_start = 0;
   logic i_user_path_block_mode = 0, i_servo_tick = 0, o_spline_active, o_queue_full;
   logic o_move_valid, o_group_stop;
   logic [7:0] i_extended_go_param = 0, o_queue_count;
   logic [47:0] i_contour_distance_set = 0, o_contour_distance;
   logic [95:0] i_target = 0, i_position = 0, i_ratio = 0, o_slave_target;
   logic [15:0] i_vector_speed_set = 0, i_vector_accel = 0, i_vector_decel = 0;
   logic [47:0] i_axis_speed_set = 0, i_axis_accel = 0, o_axis_speed;
   logic [31:0] i_master_optimal = 0, o_move_time;
   logic [2:0] i_slave_gearing_enable = 0;
   logic [3:0] i_axis_error = 0;
   int mismatches = 0, samples_checked = 0;
   cpg_contour_gear #(.NAX(3)) u_dut (
      .i_mclk(i_mclk), .i_rst(i_rst), .i_contour_synch_enable(i_contour_synch_enable),
      .i_operating_mode_set(i_operating_mode_set), .i_queue_push(i_queue_push),
      .i_extended_go(i_extended_go), .i_extended_go_param(i_extended_go_param),
      .i_point_done(i_point_done), .i_move_start(i_move_start),
      .i_user_path_block_mode(i_user_path_block_mode),
      .i_contour_distance_set(i_contour_distance_set), .i_target(i_target),
      .i_position(i_position), .i_vector_speed_set(i_vector_speed_set),
      .i_vector_accel(i_vector_accel), .i_vector_decel(i_vector_decel),
      .i_axis_speed_set(i_axis_speed_set), .i_axis_accel(i_axis_accel),
      .i_servo_tick(i_servo_tick), .i_master_optimal(i_master_optimal),
      .i_slave_gearing_enable(i_slave_gearing_enable), .i_ratio(i_ratio),
      .i_axis_error(i_axis_error), .o_spline_active(o_spline_active),
      .o_queue_count(o_queue_count), .o_queue_full(o_queue_full),
      .o_contour_distance(o_contour_distance), .o_move_time(o_move_time),
      .o_axis_speed(o_axis_speed), .o_move_valid(o_move_valid),
      .o_slave_target(o_slave_target), .o_group_stop(o_group_stop));
   initial forever #5 i_mclk = ~i_mclk;
   task automatic tally_and_finish();
      $display("checked %0d mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task automatic edge1();
      @(posedge i_mclk);
   endtask
   task automatic mv(input logic usr, input logic [47:0] d, ed, input logic [31:0] et);
      edge1(); i_user_path_block_mode <= usr; i_contour_distance_set <= d; i_move_start <= 1;
      edge1(); i_move_start <= 0;
      repeat (40)
      begin
         #1; if (o_move_valid === 1'b1) break;
         edge1();
      end
      `CHK("valid", 1'b1, o_move_valid)
      `CHK("distance", ed, o_contour_distance)
      `CHK("time", et, o_move_time)
   endtask
   task automatic mode_set();
      edge1(); i_operating_mode_set <= 1;
      edge1(); i_operating_mode_set <= 0;
      edge1(); #1;
   endtask
   task automatic tk(input logic [31:0] m, input logic [95:0] exp);
      edge1(); i_master_optimal <= m; i_servo_tick <= 1;
      edge1(); i_servo_tick <= 0; #1;
      `CHK("slave", exp, o_slave_target)
   endtask
   initial begin
      #100000; mismatches++; tally_and_finish();
   end
   initial begin
      repeat (12) edge1();
      i_rst <= 0;
      edge1(); #1;
      `CHK("stop_rst", 1'b0, o_group_stop)
      mode_set();
      edge1();
      i_vector_speed_set <= 16'h0005; i_vector_accel <= 16'h0001; i_vector_decel <= 16'h0001;
      i_target <= {32'h0000_0000, 32'h0000_0004, 32'h0000_0003};
      // orthogonal distance
      mv(1'b0, 48'h0000_0000_0000, 48'h0000_0000_0005, 32'h0000_0005);
      edge1();
      i_vector_speed_set <= 16'h0064; i_vector_accel <= 16'h0032; i_vector_decel <= 16'h0032;
      i_target <= {3{32'h0000_03E8}};
      mv(1'b1, 48'h0000_0000_2710, 48'h0000_0000_2710, 32'h0000_0066);
      // base comes from positions held at mode set, not current ones
      edge1();
      i_position <= {32'h0000_0000, 32'h0000_0000, 32'h0000_00C8};
      // mode set clears distance
      mode_set();
      `CHK("dist_clr", 48'h0000_0000_0000, o_contour_distance)
      edge1();
      i_position <= '0;
      i_axis_speed_set <= {16'h0001, 16'h0064, 16'h012C};
      i_axis_accel <= {3{16'h03E8}};
      i_target <= {32'h0000_0000, 32'h0000_03E8, 32'h0000_03E8};
      // per-axis speed mode
      mv(1'b1, 48'h0000_0000_0000, 48'h0000_0000_0708, 32'h0000_000A);
      `CHK("spd_long", 16'h0064, o_axis_speed[31:16])
      `CHK("spd_cap", 1'b1, o_axis_speed[15:0] <= 16'h012C)
      `CHK("spd_idle", 16'h0000, o_axis_speed[47:32])
      edge1();
      i_contour_synch_enable <= 1;
      i_queue_push <= 1;
      repeat (130) edge1();
      i_queue_push <= 0;
      edge1(); #1;
      `CHK("full", 1'b1, o_queue_full)
      `CHK("count", 8'h80, o_queue_count)
      edge1(); i_extended_go <= 1;
      edge1(); i_extended_go <= 0; #1;
      `CHK("go0", 1'b0, o_spline_active)
      edge1(); i_extended_go <= 1; i_extended_go_param <= 8'h01;
      edge1(); i_extended_go <= 0; #1;
      `CHK("go1", 1'b1, o_spline_active)
      edge1(); i_point_done <= 1;
      repeat (126) edge1();
      edge1(); i_point_done <= 0; #1;
      `CHK("q_left", 8'h01, o_queue_count)
      `CHK("spl_mid", 1'b1, o_spline_active)
      edge1(); i_point_done <= 1;
      edge1(); i_point_done <= 0; #1;
      `CHK("spl_end", 1'b0, o_spline_active)
      `CHK("q_end", 8'h00, o_queue_count)
      edge1(); i_queue_push <= 1;
      edge1(); edge1(); i_queue_push <= 0; i_extended_go <= 1;
      edge1(); i_extended_go <= 0; #1;
      `CHK("go2", 1'b1, o_spline_active)
      edge1(); i_contour_synch_enable <= 0;
      edge1(); edge1(); #1;
      `CHK("spl_off", 1'b0, o_spline_active)
      `CHK("q_empty", 8'h00, o_queue_count)
      edge1();
      i_ratio <= {32'h0000_8000, 32'hFFFF_0000, 32'h0002_0000};
      i_slave_gearing_enable <= 3'b111;
      // signed ratios both ways
      tk(32'h0000_0064, {32'h0000_0032, 32'hFFFF_FF9C, 32'h0000_00C8});
      tk(32'hFFFF_FFF8, {32'hFFFF_FFFC, 32'h0000_0008, 32'hFFFF_FFF0});
      edge1(); i_axis_error <= 4'b1000;
      edge1(); edge1(); #1;
      `CHK("stop", 1'b1, o_group_stop)
      tk(32'h0000_00C8, {32'hFFFF_FFFC, 32'h0000_0008, 32'hFFFF_FFF0});
      edge1(); i_axis_error <= 4'b0000; i_slave_gearing_enable <= 3'b000;
      edge1(); edge1(); #1;
      `CHK("unstop", 1'b0, o_group_stop)
      tally_and_finish();
   end
endmodule
